//--- rtl/periph_ctrl_defs.vh
// Register map, field positions and reset values of the peripheral control and settings register bank.
// Included by the register bank; holds definitions only.
`ifndef PERIPH_CTRL_DEFS_VH
`define PERIPH_CTRL_DEFS_VH

// Byte offsets on the configuration bus.
`define OFS_PERIPHERAL_CONTROL 8'h04
`define OFS_PERIPHERAL_SETTINGS_CONTROL 8'h20

// Peripheral control register fields.
`define PC_FREE_RUN_BIT 0
`define PC_SOFT_STOP_BIT 1
`define PC_FLOW_GATE_BIT 2
`define PC_RW_MASK 32'h00000007
`define PC_RESET 32'h00000001

// Settings register fields.
`define PS_PLL_LO 0
`define PS_PLL_HI 2
`define PS_PRESCALER_LO 4
`define PS_PRESCALER_HI 7
`define PS_NARROW_LANE_BIT 8
`define PS_BUS_PRI_LO 9
`define PS_BUS_PRI_HI 11
`define PS_THR_P0_LO 12
`define PS_THR_P0_HI 14
`define PS_THR_P1_LO 15
`define PS_THR_P1_HI 17
`define PS_THR_P2_LO 18
`define PS_THR_P2_HI 20
`define PS_INIT_LOCK_BIT 24
`define PS_LOOPBACK_BIT 25
`define PS_MEM_SLEEP_BIT 26
`define PS_RW_MASK 32'h071FFFF7
`define PS_RESET 32'h04053000

// AXI4-Lite response codes.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- rtl/peripheral_control_settings_regs.v
// Global control and settings register bank of a serial packet interconnect peripheral, with the
// flow gate, emulation halt control and digital loopback steering that those registers drive.
// Assumes an AXI4-Lite master on aclk, logical-layer and serializer paths on the same clock.
//
// Behaviour
// - Control bits 31..3 read zero, ignore writes.
// - Control bit 2 enables logical-layer data flow.
// - Gate cleared: no outbound transmit transactions generated.
// - Gate cleared: incoming requests are refused.
// - Free-run 0: soft-stop bit picks halt behaviour.
// - Hard stop unsupported; treated as soft stop.
// - Free-run 1: emulation suspend input ignored entirely.
// - Loopback returns transmit data to receive digitally.
// - Init lock 0 allows read-only writes; 1 blocks.
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`include "periph_ctrl_defs.vh"

module peripheral_control_settings_regs #(
  parameter DATA_W = 32
) (
  input wire aclk, // Configuration clock.
  input wire aresetn, // Synchronous reset, active low.
  input wire [7:0] s_axi_awaddr, // Write address.
  input wire s_axi_awvalid, // Write address valid.
  output reg s_axi_awready, // Write address ready.
  input wire [31:0] s_axi_wdata, // Write data.
  input wire [3:0] s_axi_wstrb, // Write byte strobes.
  input wire s_axi_wvalid, // Write data valid.
  output reg s_axi_wready, // Write data ready.
  output reg [1:0] s_axi_bresp, // Write response.
  output reg s_axi_bvalid, // Write response valid.
  input wire s_axi_bready, // Write response ready.
  input wire [7:0] s_axi_araddr, // Read address.
  input wire s_axi_arvalid, // Read address valid.
  output reg s_axi_arready, // Read address ready.
  output reg [31:0] s_axi_rdata, // Read data.
  output reg [1:0] s_axi_rresp, // Read response.
  output reg s_axi_rvalid, // Read data valid.
  input wire s_axi_rready, // Read data ready.
  input wire emu_suspend, // Emulation suspend request, level.
  input wire xfer_busy, // A logical-layer transaction is in progress.
  output reg suspended, // Peripheral has halted for emulation.
  output reg tx_generate_enable, // Initiator may issue outbound transactions.
  output reg rx_request_accept, // Target may accept incoming requests.
  input wire [DATA_W-1:0] tx_data, // Transmit data from the link layer.
  input wire tx_valid, // Transmit data valid.
  input wire [DATA_W-1:0] serdes_rx_data, // Receive data from the serializer.
  input wire serdes_rx_valid, // Receive data valid from the serializer.
  output reg [DATA_W-1:0] serdes_tx_data, // Transmit data to the serializer.
  output reg serdes_tx_valid, // Transmit data valid to the serializer.
  output reg [DATA_W-1:0] rx_data, // Receive data to the link layer.
  output reg rx_valid, // Receive data valid to the link layer.
  output reg ro_write_enable, // Writes to read-only registers allowed.
  output reg memory_sleep_override, // Keep memories awake in shutdown.
  output reg loopback, // Digital loopback selected.
  output reg [2:0] credit_threshold_p2, // Priority 2 transmit credit threshold.
  output reg [2:0] credit_threshold_p1, // Priority 1 transmit credit threshold.
  output reg [2:0] credit_threshold_p0, // Priority 0 transmit credit threshold.
  output reg [2:0] bus_transaction_priority, // Internal bus transaction priority.
  output reg narrow_lane_mode, // Single-lane port mode.
  output reg [3:0] prescaler_select, // Prescaler select.
  output reg lane_pll_enable_a, // Lane PLL enable A.
  output reg lane_pll_enable_b, // Lane PLL enable B.
  output reg lane_pll_enable_c // Lane PLL enable C.
);

  reg [31:0] control_reg;
  reg [31:0] settings_reg;
  reg aw_full_reg;
  reg w_full_reg;
  reg [7:0] awaddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  reg [31:0] control_next;
  reg [31:0] settings_next;
  reg [31:0] read_word;
  reg read_hit;
  wire [31:0] byte_mask;
  wire aw_hs;
  wire w_hs;
  wire do_write;
  wire write_hit;
  wire halt_now;

  assign aw_hs = s_axi_awvalid & s_axi_awready;
  assign w_hs = s_axi_wvalid & s_axi_wready;
  // A new write waits while the previous response is unclaimed, so two responses never overlap.
  assign do_write = aw_full_reg & w_full_reg & ~s_axi_bvalid;
  assign write_hit = (awaddr_reg == `OFS_PERIPHERAL_CONTROL) || (awaddr_reg == `OFS_PERIPHERAL_SETTINGS_CONTROL);

  genvar lane;
  generate
    for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
      assign byte_mask[lane*8 +: 8] = {8{wstrb_reg[lane]}};
    end
  endgenerate

  // Reserved bits are masked off so they never store and always read zero.
  always @* begin
    control_next = control_reg;
    settings_next = settings_reg;
    if (do_write && awaddr_reg == `OFS_PERIPHERAL_CONTROL) begin
      control_next = (control_reg & ~(byte_mask & `PC_RW_MASK)) | (wdata_reg & byte_mask & `PC_RW_MASK);
    end
    if (do_write && awaddr_reg == `OFS_PERIPHERAL_SETTINGS_CONTROL) begin
      settings_next = (settings_reg & ~(byte_mask & `PS_RW_MASK)) | (wdata_reg & byte_mask & `PS_RW_MASK);
    end
  end

  // Unmapped reads answer zero with an error response, so a stray access is visible to software.
  always @* begin
    read_word = 32'h00000000;
    read_hit = 1'b1;
    case (s_axi_araddr)
      `OFS_PERIPHERAL_CONTROL: read_word = control_reg & `PC_RW_MASK;
      `OFS_PERIPHERAL_SETTINGS_CONTROL: read_word = settings_reg & `PS_RW_MASK;
      default: read_hit = 1'b0;
    endcase
  end

  // Write address and data are taken independently; the write lands once both are held.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      control_reg <= `PC_RESET;
      settings_reg <= `PS_RESET;
    end else begin
      control_reg <= control_next;
      settings_reg <= settings_next;
      if (aw_hs) begin
        aw_full_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (!aw_full_reg) begin
        s_axi_awready <= 1'b1;
      end
      if (w_hs) begin
        w_full_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (!w_full_reg) begin
        s_axi_wready <= 1'b1;
      end
      if (do_write) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= write_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= read_word;
      s_axi_rresp <= read_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // Hard stop is not offered, so a cleared soft-stop bit halts gracefully as well.
  // The halt waits for the transaction in flight to finish rather than cutting it.
  localparam [2:0] HALT_RUN = 3'b001;
  localparam [2:0] HALT_DRAIN = 3'b010;
  localparam [2:0] HALT_STOP = 3'b100;

  reg [2:0] halt_state_reg;
  reg [2:0] halt_state_next;
  wire halt_request;

  assign halt_request = emu_suspend & ~control_reg[`PC_FREE_RUN_BIT];
  assign halt_now = halt_request & ~xfer_busy;

  // The drain state keeps the gates open until the transaction in flight completes.
  always @* begin
    halt_state_next = halt_state_reg;
    case (halt_state_reg)
      HALT_RUN: begin
        if (halt_now) begin
          halt_state_next = HALT_STOP;
        end else if (halt_request) begin
          halt_state_next = HALT_DRAIN;
        end
      end
      HALT_DRAIN: begin
        if (!halt_request) begin
          halt_state_next = HALT_RUN;
        end else if (halt_now) begin
          halt_state_next = HALT_STOP;
        end
      end
      HALT_STOP: begin
        if (!halt_request) begin
          halt_state_next = HALT_RUN;
        end
      end
      default: begin
        halt_state_next = HALT_RUN;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      halt_state_reg <= HALT_RUN;
      suspended <= 1'b0;
    end else begin
      halt_state_reg <= halt_state_next;
      suspended <= (halt_state_next == HALT_STOP);
    end
  end

  // The gate uses the next register value so new transactions stop on the same edge the write lands.
  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_generate_enable <= 1'b0;
      rx_request_accept <= 1'b0;
    end else begin
      tx_generate_enable <= control_next[`PC_FLOW_GATE_BIT] & ~halt_now & ~suspended;
      rx_request_accept <= control_next[`PC_FLOW_GATE_BIT] & ~halt_now & ~suspended;
    end
  end

  // Loopback turns transmit data round before the serializer and keeps the serializer quiet.
  always @(posedge aclk) begin
    if (!aresetn) begin
      serdes_tx_data <= {DATA_W{1'b0}};
      serdes_tx_valid <= 1'b0;
      rx_data <= {DATA_W{1'b0}};
      rx_valid <= 1'b0;
    end else if (settings_reg[`PS_LOOPBACK_BIT]) begin
      serdes_tx_data <= {DATA_W{1'b0}};
      serdes_tx_valid <= 1'b0;
      rx_data <= tx_data;
      rx_valid <= tx_valid;
    end else begin
      serdes_tx_data <= tx_data;
      serdes_tx_valid <= tx_valid;
      rx_data <= serdes_rx_data;
      rx_valid <= serdes_rx_valid;
    end
  end

  // Field outputs leave reset with the register's own reset value, so both agree from the first edge.
  localparam [31:0] SETTINGS_RESET = `PS_RESET;

  // Field outputs follow the stored value one edge after it changes.
  always @(posedge aclk) begin
    if (!aresetn) begin
      ro_write_enable <= ~SETTINGS_RESET[`PS_INIT_LOCK_BIT];
      memory_sleep_override <= SETTINGS_RESET[`PS_MEM_SLEEP_BIT];
      loopback <= SETTINGS_RESET[`PS_LOOPBACK_BIT];
      credit_threshold_p2 <= SETTINGS_RESET[`PS_THR_P2_HI:`PS_THR_P2_LO];
      credit_threshold_p1 <= SETTINGS_RESET[`PS_THR_P1_HI:`PS_THR_P1_LO];
      credit_threshold_p0 <= SETTINGS_RESET[`PS_THR_P0_HI:`PS_THR_P0_LO];
      bus_transaction_priority <= SETTINGS_RESET[`PS_BUS_PRI_HI:`PS_BUS_PRI_LO];
      narrow_lane_mode <= SETTINGS_RESET[`PS_NARROW_LANE_BIT];
      prescaler_select <= SETTINGS_RESET[`PS_PRESCALER_HI:`PS_PRESCALER_LO];
      lane_pll_enable_a <= SETTINGS_RESET[`PS_PLL_LO];
      lane_pll_enable_b <= SETTINGS_RESET[`PS_PLL_LO+1];
      lane_pll_enable_c <= SETTINGS_RESET[`PS_PLL_HI];
    end else begin
      // The lock is only exported; the registers that it protects sit elsewhere in the peripheral.
      ro_write_enable <= ~settings_reg[`PS_INIT_LOCK_BIT];
      memory_sleep_override <= settings_reg[`PS_MEM_SLEEP_BIT];
      loopback <= settings_reg[`PS_LOOPBACK_BIT];
      credit_threshold_p2 <= settings_reg[`PS_THR_P2_HI:`PS_THR_P2_LO];
      credit_threshold_p1 <= settings_reg[`PS_THR_P1_HI:`PS_THR_P1_LO];
      credit_threshold_p0 <= settings_reg[`PS_THR_P0_HI:`PS_THR_P0_LO];
      bus_transaction_priority <= settings_reg[`PS_BUS_PRI_HI:`PS_BUS_PRI_LO];
      narrow_lane_mode <= settings_reg[`PS_NARROW_LANE_BIT];
      prescaler_select <= settings_reg[`PS_PRESCALER_HI:`PS_PRESCALER_LO];
      lane_pll_enable_a <= settings_reg[`PS_PLL_LO];
      lane_pll_enable_b <= settings_reg[`PS_PLL_LO+1];
      lane_pll_enable_c <= settings_reg[`PS_PLL_HI];
    end
  end

endmodule // peripheral_control_settings_regs

//--- test/periph_monitor.sv
// Concurrent checks on the data path, halt logic and read answers of the register bank.
// Assumes it is bound to the bank's top module and sees only its ports.
`timescale 1ns/1ps
module periph_monitor (
  input wire logic aclk, // Clock.
  input wire logic aresetn, // Reset, active low.
  input wire logic s_axi_rvalid, // Read valid.
  input wire logic [31:0] s_axi_rdata, // Read data.
  input wire logic [1:0] s_axi_rresp, // Read response.
  input wire logic emu_suspend, // Suspend request.
  input wire logic xfer_busy, // Transfer busy.
  input wire logic suspended, // Halted.
  input wire logic tx_generate_enable, // Initiator gate.
  input wire logic rx_request_accept, // Target gate.
  input wire logic [31:0] tx_data, // Link transmit data.
  input wire logic tx_valid, // Link transmit valid.
  input wire logic [31:0] serdes_rx_data, // Serializer receive data.
  input wire logic serdes_rx_valid, // Serializer receive valid.
  input wire logic serdes_tx_valid, // Serializer transmit valid.
  input wire logic [31:0] serdes_tx_data, // Serializer transmit data.
  input wire logic [31:0] rx_data, // Link receive data.
  input wire logic rx_valid, // Link receive valid.
  input wire logic loopback // Loopback field.
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  loop_rx_a: assert property (tx_valid ##1 loopback |-> rx_valid && rx_data == $past(tx_data))
    else $error("loopback receive data wrong");
  loop_tx_a: assert property (tx_valid ##1 loopback |-> !serdes_tx_valid && serdes_tx_data == 32'h00000000)
    else $error("serializer driven during loopback");
  norm_tx_a: assert property (tx_valid ##1 !loopback |-> serdes_tx_valid)
    else $error("transmit data not passed to serializer");
  tx_data_pass_a: assert property (tx_valid ##1 !loopback |-> serdes_tx_data == $past(tx_data))
    else $error("serializer transmit data wrong");
  norm_rx_a: assert property (serdes_rx_valid ##1 !loopback |-> rx_valid && rx_data == $past(serdes_rx_data))
    else $error("serializer receive data wrong");
  halt_gate_a: assert property (suspended |-> !tx_generate_enable && !rx_request_accept)
    else $error("gates open while halted");
  gate_pair_a: assert property (tx_generate_enable == rx_request_accept)
    else $error("initiator and target gates differ");
  halt_cause_a: assert property ($rose(suspended) |-> $past(emu_suspend) && !$past(xfer_busy))
    else $error("halt without idle suspend request");
  err_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h00000000)
    else $error("error read returns data");
  cover property (suspended);
  cover property (loopback && rx_valid);
  cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule // periph_monitor

//--- test/peripheral_control_settings_regs_tb_top.sv
// Self-checking bench for the control and settings register bank.
// Assumes the bank alone on one clock, driven here over AXI4-Lite.
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_mismatch++; $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module peripheral_control_settings_regs_tb_top;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic emu_suspend, xfer_busy, tx_valid, serdes_rx_valid;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, tx_data, serdes_rx_data, s_axi_rdata, serdes_tx_data, rx_data;
  logic [3:0] s_axi_wstrb, prescaler_select;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, suspended, tx_generate_enable;
  logic rx_request_accept, serdes_tx_valid, rx_valid, ro_write_enable, memory_sleep_override, loopback;
  logic narrow_lane_mode, lane_pll_enable_a, lane_pll_enable_b, lane_pll_enable_c;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [2:0] credit_threshold_p2, credit_threshold_p1, credit_threshold_p0, bus_transaction_priority;
  logic [31:0] d;
  int n_mismatch, check_count;
  typedef struct {logic [7:0] a; logic [31:0] wd, rd; logic [1:0] rs; logic [22:0] f;} row_t;
  // Each row writes, reads back and checks the response and the exported field outputs.
  row_t rows[5] = '{'{8'h20, 32'hFFFFFFFF, 32'h071FFFF7, 2'h0, 23'h6FFFFF},
    '{8'h04, 32'hFFFFFFFF, 32'h00000007, 2'h0, 23'h6FFFFF}, '{8'h40, 32'hFFFFFFFF, 32'h00000000, 2'h2, 23'h6FFFFF},
    '{8'h20, 32'h00000000, 32'h00000000, 2'h0, 23'h100000}, '{8'h04, 32'h00000004, 32'h00000004, 2'h0, 23'h100000}};
  wire [22:0] flds = {memory_sleep_override, loopback, ro_write_enable, credit_threshold_p2, credit_threshold_p1,
    credit_threshold_p0, bus_transaction_priority, narrow_lane_mode, prescaler_select, lane_pll_enable_c,
    lane_pll_enable_b, lane_pll_enable_a};

  peripheral_control_settings_regs peripheral_control_settings_regs_inst (.*);

  initial begin
    aclk = 0;
    forever #20 aclk = ~aclk;
  end

  // Free-running traffic so that both data path modes carry data.
  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_data <= 32'h00000000;
      tx_valid <= 1'b0;
      serdes_rx_data <= 32'h00000000;
      serdes_rx_valid <= 1'b0;
    end else begin
      tx_data <= tx_data + 32'h01010101;
      tx_valid <= ~tx_valid;
      serdes_rx_data <= serdes_rx_data - 32'h00000101;
      serdes_rx_valid <= tx_valid;
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!(s_axi_awready || !s_axi_awvalid) || !(s_axi_wready || !s_axi_wvalid));
    do @(posedge aclk); while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (!s_axi_rvalid);
    v = s_axi_rdata; rs = s_axi_rresp;
    s_axi_rready <= 0;
  endtask

  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge aclk);
    n_mismatch++;
    wrap_up;
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
    {emu_suspend, xfer_busy, s_axi_awaddr, s_axi_araddr} = 0;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hF;
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    rd(8'h04, d, r); `CHK(d, 32'h00000001)
    rd(8'h20, d, r); `CHK(d, 32'h04053000)
    `CHK({flds, tx_generate_enable}, {23'h529800, 1'b0})
    $display("reset test done");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].wd, r); `CHK(r, rows[i].rs)
      rd(rows[i].a, d, r); `CHK({d, r}, {rows[i].rd, rows[i].rs})
      `CHK(flds, rows[i].f)
      $display("row %0d done", i);
    end
    `CHK({tx_generate_enable, rx_request_accept}, 2'b11)
    emu_suspend <= 1; xfer_busy <= 1;
    repeat (4) @(posedge aclk);
    `CHK({suspended, tx_generate_enable}, 2'b01)
    xfer_busy <= 0;
    repeat (3) @(posedge aclk);
    `CHK({suspended, tx_generate_enable, rx_request_accept}, 3'b100)
    wr(8'h04, 32'h00000005, r);
    repeat (2) @(posedge aclk);
    `CHK({suspended, tx_generate_enable, rx_request_accept}, 3'b011)
    wr(8'h04, 32'h00000001, r);
    repeat (2) @(posedge aclk);
    `CHK({tx_generate_enable, rx_request_accept}, 2'b00)
    emu_suspend <= 0;
    $display("halt test done");
    s_axi_wstrb <= 4'h2;
    wr(8'h20, 32'hFFFFFFFF, r);
    s_axi_wstrb <= 4'hF;
    rd(8'h20, d, r); `CHK(d, 32'h0000FF00)
    `CHK(flds, 23'h107F80)
    $display("strobe test done");
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rd(8'h04, d, r); `CHK(d, 32'h00000001)
    rd(8'h20, d, r); `CHK(d, 32'h04053000)
    `CHK({flds, tx_generate_enable, suspended}, {23'h529800, 2'b00})
    $display("mid-run reset test done");
    wrap_up;
  end
endmodule // peripheral_control_settings_regs_tb_top

bind peripheral_control_settings_regs periph_monitor periph_monitor_inst (.*);
